// [rtl/etf_mac_end.sv]
`timescale 1ns/1ns
// Function
// - start frame only after frame ready high
// - word request is one-cycle pulse
// - buffer answers each request with one-cycle valid
// - data width follows bus width, valid-qualified
// - first marker on opening word
// - last marker on closing word
// - byte count on last word, zero means all
// - error flag accepted on any word
// - underflow honoured only between request and valid
// - no requests until flushed high then low
// - any status bit set triggers a flush
// - skip fcs flag taken with first word
// - buffer inputs arrive already clock-aligned
// - done toggle flips per frame, except a frame that ends in underflow, status valid
// - no done toggle on collision retry
// - ack toggle per event, synchronised in
// - underrun: underflow, error, early write-back
// - half duplex collision sets bit two
// - half duplex late collision on bit one
// - half duplex excess retries on bit zero
module etf_mac_end
(
   input wire logic mclk,
   input wire logic rst_n,
   etf_if.mac lnk,
   input wire logic [1:0] bus_width,
   input wire logic half_duplex,
   input wire logic coll_ev,
   input wire logic late_coll_ev,
   input wire logic excess_ev,
   output logic tx_vld,
   output logic [etf_pkg::DATA_W-1:0] tx_data,
   output logic tx_first,
   output logic tx_last,
   output logic [etf_pkg::MOD_W-1:0] tx_mod,
   output logic tx_no_fcs,
   output logic tx_abort
);
   typedef enum logic [2:0] {S_IDLE, S_REQ, S_WAIT, S_DONE, S_FL_HI, S_FL_LO} etf_st_e;
   etf_st_e st_r;
   logic req_r;
   logic done_tog_r;
   logic [3:0] status_r;
   logic [3:0] st_set;
   logic ack_pend_r;
   logic ack_s1_r;
   logic ack_s2_r;
   logic ack_s3_r;
   logic ack_chg;
   logic err_seen_r;
   logic in_frame;
   logic hd_coll;
   logic hd_abort;
   logic [etf_pkg::DATA_W-1:0] lane_mask;

   assign lnk.word_req = req_r;
   assign lnk.frame_done_tog = done_tog_r;
   assign lnk.tx_status = status_r;

   // ack toggle is asynchronous, two flops then edge detect
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
         ack_s3_r <= 1'b0;
      end
      else
      begin
         ack_s1_r <= lnk.status_ack_tog;
         ack_s2_r <= ack_s1_r;
         ack_s3_r <= ack_s2_r;
      end
   end
   assign ack_chg = ack_s2_r ^ ack_s3_r;

   // collision events count only in half duplex and mid frame
   assign in_frame = (st_r == S_REQ) || (st_r == S_WAIT);
   assign hd_coll = half_duplex && in_frame && coll_ev;
   assign hd_abort = half_duplex && in_frame && !coll_ev && (late_coll_ev || excess_ev);

   // bytes above the configured width are not carried
   always_comb
   begin
      lane_mask = '1;
      if (bus_width == etf_pkg::BW_32)
      begin
         lane_mask = {{(etf_pkg::DATA_W-32){1'b0}}, {32{1'b1}}};
      end
      else if (bus_width == etf_pkg::BW_64)
      begin
         lane_mask = {{(etf_pkg::DATA_W-64){1'b0}}, {64{1'b1}}};
      end
   end

   // status set terms; a set in the clearing cycle wins
   always_comb
   begin
      st_set = etf_pkg::ST_NONE;
      if (st_r == S_WAIT && !lnk.word_vld && lnk.underflow)
      begin
         st_set[etf_pkg::ST_UNDERRUN] = 1'b1;
      end
      if (st_r == S_DONE && (err_seen_r || (ack_pend_r && !ack_chg)))
      begin
         st_set[etf_pkg::ST_UNDERRUN] = 1'b1;
      end
      if (hd_coll)
      begin
         st_set[etf_pkg::ST_COLL] = 1'b1;
      end
      if (hd_abort && late_coll_ev)
      begin
         st_set[etf_pkg::ST_LATE] = 1'b1;
      end
      if (hd_abort && !late_coll_ev)
      begin
         st_set[etf_pkg::ST_EXCESS] = 1'b1;
      end
   end

   // bits only move on their own set or on an ack edge
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_r <= etf_pkg::ST_NONE;
      end
      else
      begin
         status_r <= (status_r & ~{4{ack_chg}}) | st_set;
      end
   end

   // one acknowledge outstanding per done toggle or collision
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_pend_r <= 1'b0;
      end
      else if (st_r == S_DONE || hd_coll)
      begin
         ack_pend_r <= 1'b1;
      end
      else if (ack_chg)
      begin
         ack_pend_r <= 1'b0;
      end
   end

   // packet error is remembered until the frame closes
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         err_seen_r <= 1'b0;
      end
      else if (st_r == S_IDLE)
      begin
         err_seen_r <= 1'b0;
      end
      else if (st_r == S_WAIT && lnk.word_vld && lnk.word_err)
      begin
         err_seen_r <= 1'b1;
      end
   end

   // frame sequencer
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= S_IDLE;
         req_r <= 1'b0;
         done_tog_r <= 1'b0;
      end
      else
      begin
         req_r <= 1'b0;
         case (st_r)
            S_IDLE:
            begin
               if (lnk.frame_rdy)
               begin
                  st_r <= S_REQ;
               end
            end
            S_REQ:
            begin
               if (hd_coll)
               begin
                  st_r <= S_FL_HI;
               end
               else if (hd_abort)
               begin
                  st_r <= S_DONE;
               end
               else
               begin
                  req_r <= 1'b1;
                  st_r <= S_WAIT;
               end
            end
            S_WAIT:
            begin
               if (hd_coll)
               begin
                  st_r <= S_FL_HI;
               end
               else if (hd_abort)
               begin
                  st_r <= S_DONE;
               end
               else if (lnk.word_vld)
               begin
                  st_r <= lnk.word_last ? S_DONE : S_REQ;
               end
               else if (lnk.underflow)
               begin
                  st_r <= S_FL_HI;
               end
            end
            S_DONE:
            begin
               done_tog_r <= ~done_tog_r;
               // status goes nonzero whenever the far side must flush
               if ((status_r & ~{4{ack_chg}}) != etf_pkg::ST_NONE || st_set != etf_pkg::ST_NONE)
               begin
                  st_r <= S_FL_HI;
               end
               else
               begin
                  st_r <= S_IDLE;
               end
            end
            S_FL_HI:
            begin
               if (lnk.flushed)
               begin
                  st_r <= S_FL_LO;
               end
            end
            S_FL_LO:
            begin
               if (!lnk.flushed)
               begin
                  st_r <= S_IDLE;
               end
            end
            default:
            begin
               st_r <= S_IDLE;
            end
         endcase
      end
   end

   // words out to the transmit core, registered
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_vld <= 1'b0;
         tx_data <= '0;
         tx_first <= 1'b0;
         tx_last <= 1'b0;
         tx_mod <= '0;
         tx_no_fcs <= 1'b0;
         tx_abort <= 1'b0;
      end
      else
      begin
         tx_vld <= 1'b0;
         tx_abort <= hd_coll || hd_abort || (st_r == S_WAIT && !lnk.word_vld && lnk.underflow);
         if (st_r == S_WAIT && lnk.word_vld && !hd_coll && !hd_abort)
         begin
            tx_vld <= 1'b1;
            tx_data <= lnk.word_data & lane_mask;
            tx_first <= lnk.word_first;
            tx_last <= lnk.word_last;
            tx_mod <= lnk.word_last ? lnk.word_mod : '0;
            tx_no_fcs <= lnk.word_first && lnk.no_fcs;
         end
      end
   end
endmodule

// [include/etf_pkg.sv]
package etf_pkg;
   // widest word and byte count field
   localparam int DATA_W = 128;
   localparam int MOD_W = 4;
   // bus width codes on bus_width
   localparam logic [1:0] BW_32 = 2'h0;
   localparam logic [1:0] BW_64 = 2'h1;
   // status bit positions
   localparam int ST_UNDERRUN = 3;
   localparam int ST_COLL = 2;
   localparam int ST_LATE = 1;
   localparam int ST_EXCESS = 0;
   localparam logic [3:0] ST_NONE = 4'h0;
   // buffer shape and packing of one buffered word
   localparam int BUF_DEPTH = 16;
   localparam int CNT_W = 5;
   localparam int FW_DATA = 0;
   localparam int FW_MOD = DATA_W;
   localparam int FW_FIRST = DATA_W + MOD_W;
   localparam int FW_LAST = FW_FIRST + 1;
   localparam int FW_ERR = FW_FIRST + 2;
   localparam int FW_NOFCS = FW_FIRST + 3;
   localparam int BUF_W = FW_FIRST + 4;
endpackage

// [include/etf_if.sv]
`timescale 1ns/1ns
interface etf_if;
   logic frame_rdy;
   logic word_req;
   logic word_vld;
   logic [etf_pkg::DATA_W-1:0] word_data;
   logic word_first;
   logic word_last;
   logic [etf_pkg::MOD_W-1:0] word_mod;
   logic word_err;
   logic underflow;
   logic flushed;
   logic no_fcs;
   logic frame_done_tog;
   logic status_ack_tog;
   logic [3:0] tx_status;
   // transmitter end
   modport mac
   (
      input frame_rdy, word_vld, word_data, word_first, word_last, word_mod,
      input word_err, underflow, flushed, no_fcs, status_ack_tog,
      output word_req, frame_done_tog, tx_status
   );
   // external buffer end
   modport fifo
   (
      output frame_rdy, word_vld, word_data, word_first, word_last, word_mod,
      output word_err, underflow, flushed, no_fcs, status_ack_tog,
      input word_req, frame_done_tog, tx_status
   );
endinterface

// [rtl/etf_fifo.sv]
`timescale 1ns/1ns
module etf_fifo #(
   parameter int WIDTH = etf_pkg::BUF_W,
   parameter int DEPTH = etf_pkg::BUF_DEPTH
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic in_vld,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_rdy,
   output logic out_vld,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_rdy
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic [AW:0] cnt_nxt;
   logic push;
   logic pop;

   // ready is registered from the next count so it leaves a flop
   assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   assign out_vld = (cnt_r != '0);
   assign out_data = mem[rd_r];
   assign push = in_vld && in_rdy;
   assign pop = out_vld && out_rdy;

   // storage has no reset, pointers do
   always_ff @(posedge mclk)
   begin
      if (push)
      begin
         mem[wr_r] <= in_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
         in_rdy <= 1'b1; // empty buffer can take a word
      end
      else
      begin
         if (push)
         begin
            wr_r <= wr_r + 1'b1;
         end
         if (pop)
         begin
            rd_r <= rd_r + 1'b1;
         end
         cnt_r <= cnt_nxt;
         in_rdy <= (cnt_nxt != (AW+1)'(DEPTH));
      end
   end
endmodule

// [rtl/etf_fifo_end.sv]
`timescale 1ns/1ns
module etf_fifo_end
(
   input wire logic mclk,
   input wire logic rst_n,
   etf_if.fifo lnk,
   input wire logic in_vld,
   output logic in_rdy,
   input wire logic [etf_pkg::DATA_W-1:0] in_data,
   input wire logic in_first,
   input wire logic in_last,
   input wire logic [etf_pkg::MOD_W-1:0] in_mod,
   input wire logic in_err,
   input wire logic in_no_fcs,
   output logic rep_vld,
   output logic [3:0] rep_status
);
   typedef enum logic [1:0] {F_RUN, F_DRAIN, F_HI, F_LO} etf_fl_e;
   etf_fl_e fs_r;
   logic [etf_pkg::BUF_W-1:0] head;
   logic head_vld;
   logic pop;
   logic pop_last;
   logic push_last;
   logic [etf_pkg::CNT_W-1:0] eop_cnt_r;
   logic in_pkt_r;
   logic frame_rdy_r;
   logic vld_r;
   logic [etf_pkg::BUF_W-1:0] word_r;
   logic under_r;
   logic flushed_r;
   logic ack_r;
   logic done_prev_r;
   logic [3:0] stat_prev_r;
   logic ack_ev;

   // buffer holds whole words with their markers
   etf_fifo #(.WIDTH(etf_pkg::BUF_W), .DEPTH(etf_pkg::BUF_DEPTH)) u_buf
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_vld(in_vld),
      .in_data({in_no_fcs, in_err, in_last, in_first, in_mod, in_data}),
      .in_rdy(in_rdy),
      .out_vld(head_vld),
      .out_data(head),
      .out_rdy(pop)
   );

   // pop for a request while running, or to discard while draining
   assign pop = head_vld && ((fs_r == F_RUN && lnk.word_req) || (fs_r == F_DRAIN && in_pkt_r));
   assign pop_last = pop && head[etf_pkg::FW_LAST];
   assign push_last = in_vld && in_rdy && in_last;
   assign ack_ev = (lnk.frame_done_tog != done_prev_r)
      || (lnk.tx_status[etf_pkg::ST_COLL] && !stat_prev_r[etf_pkg::ST_COLL]);

   assign lnk.frame_rdy = frame_rdy_r;
   assign lnk.word_vld = vld_r;
   assign lnk.word_data = word_r[etf_pkg::FW_DATA +: etf_pkg::DATA_W];
   assign lnk.word_mod = word_r[etf_pkg::FW_MOD +: etf_pkg::MOD_W];
   assign lnk.word_first = word_r[etf_pkg::FW_FIRST];
   assign lnk.word_last = word_r[etf_pkg::FW_LAST];
   assign lnk.word_err = word_r[etf_pkg::FW_ERR];
   assign lnk.no_fcs = word_r[etf_pkg::FW_NOFCS];
   assign lnk.underflow = under_r;
   assign lnk.flushed = flushed_r;
   assign lnk.status_ack_tog = ack_r;

   // ready once a whole packet sits in the buffer
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         eop_cnt_r <= '0;
         frame_rdy_r <= 1'b0;
         in_pkt_r <= 1'b0;
      end
      else
      begin
         eop_cnt_r <= eop_cnt_r + etf_pkg::CNT_W'(push_last) - etf_pkg::CNT_W'(pop_last);
         frame_rdy_r <= (eop_cnt_r + etf_pkg::CNT_W'(push_last) - etf_pkg::CNT_W'(pop_last)) != '0;
         if (pop)
         begin
            in_pkt_r <= !head[etf_pkg::FW_LAST];
         end
      end
   end

   // answer each request one cycle later, or report empty
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vld_r <= 1'b0;
         word_r <= '0;
         under_r <= 1'b0;
      end
      else
      begin
         vld_r <= (fs_r == F_RUN) && pop;
         under_r <= (fs_r == F_RUN) && lnk.word_req && !head_vld;
         if (fs_r == F_RUN && pop)
         begin
            word_r <= head;
         end
      end
   end

   // flush: drop rest of the open packet, then pulse flushed
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fs_r <= F_RUN;
         flushed_r <= 1'b0;
      end
      else
      begin
         case (fs_r)
            F_RUN:
            begin
               if ((lnk.word_req && !head_vld) || |(lnk.tx_status & ~stat_prev_r))
               begin
                  fs_r <= F_DRAIN;
               end
            end
            F_DRAIN:
            begin
               if (!in_pkt_r || pop_last)
               begin
                  fs_r <= F_HI;
                  flushed_r <= 1'b1;
               end
            end
            F_HI:
            begin
               fs_r <= F_LO;
               flushed_r <= 1'b0;
            end
            F_LO:
            begin
               fs_r <= F_RUN;
            end
            default:
            begin
               fs_r <= F_RUN;
            end
         endcase
      end
   end

   // acknowledge each done toggle and each collision report
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_r <= 1'b0;
         done_prev_r <= 1'b0;
         stat_prev_r <= etf_pkg::ST_NONE;
         rep_vld <= 1'b0;
         rep_status <= etf_pkg::ST_NONE;
      end
      else
      begin
         done_prev_r <= lnk.frame_done_tog;
         stat_prev_r <= lnk.tx_status;
         rep_vld <= ack_ev;
         if (ack_ev)
         begin
            ack_r <= ~ack_r;
            rep_status <= lnk.tx_status;
         end
      end
   end
endmodule

// [verification/etf_lnk_checker.sv]
`timescale 1ns/1ns
module etf_lnk_checker
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic frame_rdy,
   input wire logic word_req,
   input wire logic word_vld,
   input wire logic word_first,
   input wire logic word_last,
   input wire logic underflow,
   input wire logic flushed,
   input wire logic frame_done_tog,
   input wire logic status_ack_tog,
   input wire logic [3:0] tx_status
);
   logic open_r;
   logic hold_r;
   logic ack_prev_r;
   logic [3:0] st_prev_r;
   logic [3:0] ack_age_r;

   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // open from opening word until closing word or a flush drops the rest
   always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
         open_r <= 1'b0;
      else if (flushed || (word_vld && word_last))
         open_r <= 1'b0;
      else if (word_vld)
         open_r <= 1'b1;

   // fault seen; set one cycle late so a request already in flight is not blamed
   always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
         hold_r <= 1'b0;
      else if (flushed)
         hold_r <= 1'b0;
      else if (underflow || (tx_status & ~st_prev_r) != 4'h0)
         hold_r <= 1'b1;

   // previous status and cycles since the last acknowledge flip
   always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
      begin
         st_prev_r <= 4'h0;
         ack_prev_r <= 1'b0;
         ack_age_r <= 4'h0;
      end
      else
      begin
         st_prev_r <= tx_status;
         ack_prev_r <= status_ack_tog;
         if (status_ack_tog != ack_prev_r)
            ack_age_r <= 4'h0;
         else if (ack_age_r != 4'hF)
            ack_age_r <= ack_age_r + 4'h1;
      end

   sequence last_word_s;
      word_vld && word_last;
   endsequence
   sequence done_flip_s;
      ##2 $changed(frame_done_tog);
   endsequence
   sequence ack_flip_s;
      ##[1:4] $changed(status_ack_tog);
   endsequence

   req_pulse_a: assert property (word_req |=> !word_req)
      else $error("request wider than one cycle");
   req_answer_a: assert property (word_req |=> word_vld || underflow)
      else $error("request not answered next cycle");
   single_req_a: assert property (word_vld |=> !word_req)
      else $error("request right after valid");
   underflow_cause_a: assert property (underflow |-> $past(word_req))
      else $error("underflow without request");
   start_after_rdy_a: assert property (word_req && !open_r |-> $past(frame_rdy, 2))
      else $error("frame started without frame ready");
   first_word_a: assert property (word_vld && !open_r |-> word_first)
      else $error("opening word lacks first marker");
   done_after_last_a: assert property (last_word_s |-> done_flip_s)
      else $error("no done flip after closing word");
   done_ack_a: assert property ($changed(frame_done_tog) |-> ack_flip_s)
      else $error("done flip not acknowledged");
   coll_ack_a: assert property ($rose(tx_status[etf_pkg::ST_COLL]) |-> ack_flip_s)
      else $error("collision not acknowledged");
   coll_no_done_a: assert property ($rose(tx_status[etf_pkg::ST_COLL]) |=>
      $stable(frame_done_tog)[*4])
      else $error("done flipped on collision retry");
   status_hold_a: assert property ((($past(tx_status) & ~tx_status) != 4'h0) |->
      ack_age_r <= 4'h4)
      else $error("status cleared without acknowledge");
   flush_wait_a: assert property (hold_r |-> !word_req)
      else $error("request before flush finished");
   flush_follows_a: assert property ($rose(hold_r) |-> ##[0:40] flushed)
      else $error("fault not followed by flush");
endmodule

// [verification/ext_tx_fifo_mac_port_tb_top.sv]
`timescale 1ns/1ns
module ext_tx_fifo_mac_port_tb_top;
   localparam logic [127:0] PAT = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
   localparam logic [127:0] ALL = ~128'h0;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] bus_width = 2'h2;
   logic half_duplex = 1'b0;
   logic coll_ev = 1'b0;
   logic late_coll_ev = 1'b0;
   logic excess_ev = 1'b0;
   logic in_vld = 1'b0;
   logic [127:0] in_data = 128'h0;
   logic in_first = 1'b0;
   logic in_last = 1'b0;
   logic [3:0] in_mod = 4'h0;
   logic in_err = 1'b0;
   logic in_no_fcs = 1'b0;
   logic tx_vld, tx_first, tx_last, tx_no_fcs, in_rdy, rep_vld, tog0, tx_abort;
   logic [127:0] tx_data;
   logic [3:0] tx_mod;
   logic [3:0] rep_status;
   int failures = 0;
   int n_compared = 0;

   etf_if etf_if_i ();
   etf_mac_end etf_mac_end_i (.mclk(mclk), .rst_n(rst_n), .lnk(etf_if_i),
      .bus_width(bus_width), .half_duplex(half_duplex), .coll_ev(coll_ev),
      .late_coll_ev(late_coll_ev), .excess_ev(excess_ev), .tx_vld(tx_vld),
      .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last), .tx_mod(tx_mod),
      .tx_no_fcs(tx_no_fcs), .tx_abort(tx_abort));
   etf_fifo_end etf_fifo_end_i (.mclk(mclk), .rst_n(rst_n), .lnk(etf_if_i),
      .in_vld(in_vld), .in_rdy(in_rdy), .in_data(in_data), .in_first(in_first),
      .in_last(in_last), .in_mod(in_mod), .in_err(in_err), .in_no_fcs(in_no_fcs),
      .rep_vld(rep_vld), .rep_status(rep_status));
   etf_lnk_checker etf_lnk_checker_i (.mclk(mclk), .rst_n(rst_n),
      .frame_rdy(etf_if_i.frame_rdy), .word_req(etf_if_i.word_req),
      .word_vld(etf_if_i.word_vld), .word_first(etf_if_i.word_first),
      .word_last(etf_if_i.word_last), .underflow(etf_if_i.underflow),
      .flushed(etf_if_i.flushed), .frame_done_tog(etf_if_i.frame_done_tog),
      .status_ack_tog(etf_if_i.status_ack_tog), .tx_status(etf_if_i.tx_status));

   // free-running clock, 4 ns period
   initial
      forever #2 mclk = ~mclk;

   task chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // every drive lands 1 ns after the edge, clear of the sampling edge
   task step;
      @(posedge mclk);
      #1;
   endtask

   // n words, markers on ends, error flag on the opening word
   task pkt(input int n, input logic [3:0] m, input logic e, input logic nf);
      for (int i = 0; i < n; i++)
      begin
         in_vld = 1'b1;
         in_data = PAT ^ 128'(i);
         in_first = (i == 0);
         in_last = (i == n - 1);
         in_mod = (i == n - 1) ? m : 4'h0;
         in_err = (i == 0) && e;
         in_no_fcs = (i == 0) && nf;
         // ready seen now is what the next edge samples
         for (int k = 0; k < 50 && in_rdy !== 1'b1; k++)
            step;
         step;
      end
      in_vld = 1'b0;
   endtask

   task rx(input int i, input int n, input logic [3:0] m, input logic nf,
      input logic [127:0] msk);
      step;
      for (int k = 0; k < 200 && tx_vld !== 1'b1; k++)
         step;
      chk("tx_data", tx_data, (PAT ^ 128'(i)) & msk);
      chk("tx_first", tx_first, i == 0);
      chk("tx_last", tx_last, i == n - 1);
      chk("tx_mod", tx_mod, (i == n - 1) ? m : 4'h0);
      chk("tx_no_fcs", tx_no_fcs, (i == 0) && nf);
      chk("tx_abort", tx_abort, 1'b0);
   endtask

   // long settle lets a wrongly taken extra frame flip done once more
   task rep(input logic [3:0] st, input logic flip);
      step;
      for (int k = 0; k < 200 && rep_vld !== 1'b1; k++)
         step;
      chk("rep_status", rep_status, st);
      repeat (40)
         step;
      chk("frame_done_tog", etf_if_i.frame_done_tog, tog0 ^ flip);
   endtask

   task t_frame;
      tog0 = etf_if_i.frame_done_tog;
      pkt(2, 4'h3, 1'b0, 1'b1);
      rx(0, 2, 4'h3, 1'b1, ALL);
      rx(1, 2, 4'h3, 1'b1, ALL);
      rep(4'h0, 1'b1);
      $display("test frame done");
   endtask

   task t_width;
      for (int b = 0; b < 3; b++)
      begin
         bus_width = 2'(b);
         tog0 = etf_if_i.frame_done_tog;
         pkt(1, 4'hF, 1'b0, 1'b0);
         rx(0, 1, 4'hF, 1'b0, b == 0 ? 128'hFFFF_FFFF : b == 1 ? 128'hFFFF_FFFF_FFFF_FFFF : ALL);
         rep(4'h0, 1'b1);
      end
      bus_width = 2'h2;
      $display("test width done");
   endtask

   task t_err;
      tog0 = etf_if_i.frame_done_tog;
      pkt(2, 4'h0, 1'b1, 1'b0);
      rx(0, 2, 4'h0, 1'b0, ALL);
      rx(1, 2, 4'h0, 1'b0, ALL);
      rep(4'h8, 1'b1);
      $display("test error done");
   endtask

   // collision retries, late collision and excess retries in turn
   task t_abort;
      half_duplex = 1'b1;
      for (int j = 0; j < 3; j++)
      begin
         tog0 = etf_if_i.frame_done_tog;
         pkt(3, 4'h0, 1'b0, 1'b0);
         rx(0, 3, 4'h0, 1'b0, ALL);
         coll_ev = (j == 0);
         late_coll_ev = (j == 1);
         excess_ev = (j == 2);
         step;
         {coll_ev, late_coll_ev, excess_ev} = 3'h0;
         chk("tx_abort", tx_abort, 1'b1);
         rep(j == 0 ? 4'h4 : j == 1 ? 4'h2 : 4'h1, j != 0);
      end
      half_duplex = 1'b0;
      $display("test abort done");
   endtask

   // fill the buffer, offer one more whole packet while full, then drain
   task t_full;
      tog0 = etf_if_i.frame_done_tog;
      pkt(16, 4'h1, 1'b0, 1'b0);
      step;
      chk("in_rdy", in_rdy, 1'b0);
      {in_vld, in_first, in_last} = 3'h7;
      step;
      in_vld = 1'b0;
      for (int i = 0; i < 16; i++)
         rx(i, 16, 4'h1, 1'b0, ALL);
      rep(4'h0, 1'b1);
      chk("frame_rdy", etf_if_i.frame_rdy, 1'b0);
      $display("test full done");
   endtask

   initial
   begin
      repeat (16)
         @(posedge mclk);
      #1;
      rst_n = 1'b1;
      step;
      t_frame;
      t_width;
      t_err;
      t_frame;
      t_abort;
      t_full;
      wrap_up;
   end

   // run should take several hundred cycles
   initial
   begin
      repeat (20000)
         @(posedge mclk);
      failures++;
      $display("mismatch watchdog expected finish seen hang");
      wrap_up;
   end
endmodule
